/* File: verilog/reset_seq_pkg.sv */
package reset_seq_pkg;
   // Clock and time figures.
   localparam int CLK_PERIOD_NS      = 40;
   localparam int POWER_UP_DELAY_TIMER_TIME_US       = 72000;
   localparam int POWER_UP_DELAY_TIMER_CYCLES        = POWER_UP_DELAY_TIMER_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int CPU_START_TIME_NS  = 5000;
   localparam int CPU_START_CYCLES   = (CPU_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_OSC_CYCLES  = 1024;
   localparam int CNT_W              = 21;
   localparam int PC_W               = 13;

   // Register byte offsets.
   localparam logic [7:0] OFS_CAUSE    = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_PC       = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_SEQ      = 8'h14;

   // Field positions.
   localparam int BROWNOUT_BIT = 0;
   localparam int POWERON_BIT  = 1;
   localparam int STAT_TO_BIT  = 4;
   localparam int STAT_PD_BIT  = 3;
   localparam int IRQ_BOR      = 0;
   localparam int IRQ_PIN      = 1;
   localparam int IRQ_WDT      = 2;
   localparam int IRQ_WAKE     = 3;
   localparam int IRQ_READY    = 4;
   localparam int IRQ_W        = 5;

   // Values after reset and load values.
   localparam logic [1:0]      CAUSE_RST  = 2'h0;
   localparam logic [7:0]      STATUS_POR = 8'h18;
   localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
   localparam logic [PC_W-1:0] PC_VECTOR  = 13'h0004;

   typedef enum logic [2:0] {
      OSC_LP    = 3'h0,
      OSC_XT    = 3'h1,
      OSC_HS    = 3'h2,
      OSC_EXTERNAL_RC_CLOCK_MODE = 3'h3,
      OSC_INTERNAL_RC_CLOCK_MODE = 3'h4,
      OSC_SECONDARY_TIMER_OSCILLATOR = 3'h5
   } osc_mode_t;

   typedef enum logic [5:0] {
      ST_START    = 6'h01,
      ST_BROWNOUT = 6'h02,
      ST_POWER_UP_DELAY_TIMER     = 6'h04,
      ST_SETTLE   = 6'h08,
      ST_CPU      = 6'h10,
      ST_RUN      = 6'h20
   } seq_state_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } avm_rsp_t;
endpackage

/* File: verilog/reset_timeout_and_cause_tracker.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - After power-on run power-up delay if enabled, then 1024 oscillator cycles in crystal modes.
// - Pin held low past all delays releases execution at once when it rises.
// - Brown-out flag, bit 0, cleared by brown-out reset; software sets it.
// - Power-on flag, bit 1, cleared only by power-on reset; software sets it.
// - CPU start-up delay on wake in non-crystal modes; on power-on and brown-out only when the power-up delay is disabled.
// - RC modes skip the settle count; use power-up delay or start-up delay only.
// - Power-on sets both time-out and sleep flags.
// - Power-on always sets the sleep flag; never cleared with power-on flag clear.
// - Pin reset while running leaves time-out and sleep flags unchanged.
// - Pin reset in sleep or interrupt wake sets time-out, clears sleep flag.
// - Resets load program counter zero; watchdog or interrupt wake loads PC plus one.
// - Interrupt wake with global enable loads the interrupt vector.
// - Power-on status image is bank bits clear, time-out and sleep flags set.
// - Pin reset in sleep clears bank bits, sets time-out, clears sleep flag.
// - Stay in reset during brown-out; a new dip restarts the sequence and delay.
// - Power-up delay enable and brown-out enable are independent.
// - Watchdog held in reset while the settle count runs.
module reset_timeout_and_cause_tracker #(
   parameter int POWER_UP_DELAY_TIMER_CYCLES_P   = reset_seq_pkg::POWER_UP_DELAY_TIMER_CYCLES,
   parameter int SETTLE_CYCLES_P = reset_seq_pkg::SETTLE_OSC_CYCLES
) (
   // Clock and power-on reset
   input  wire logic                            clk_i,
   input  wire logic                            reset_i,
   // Register bus
   input  wire reset_seq_pkg::avm_req_t         bus_i,
   output var  reset_seq_pkg::avm_rsp_t         bus_o,
   // Supply, pin and configuration
   input  wire logic                            brownout_i,
   input  wire logic                            brownout_enable_i,
   input  wire logic                            power_up_delay_enable_n_i,
   input  wire reset_seq_pkg::osc_mode_t        osc_mode_i,
   input  wire logic                            external_reset_pin_n_i,
   input  wire logic                            osc_clk_i,
   // Core side
   input  wire logic                            sleeping_i,
   input  wire logic                            watchdog_expire_i,
   input  wire logic                            wake_irq_i,
   input  wire logic                            global_irq_enable_i,
   input  wire logic [reset_seq_pkg::PC_W-1:0]  current_pc_i,
   output logic                                 cpu_hold_o,
   output logic                                 pc_load_o,
   output logic [reset_seq_pkg::PC_W-1:0]       pc_value_o,
   output logic [7:0]                           status_value_o,
   output logic                                 watchdog_hold_o,
   output logic                                 irq_o
);
   import reset_seq_pkg::*;

   function automatic logic is_crystal(input osc_mode_t m);
      is_crystal = (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
   endfunction

   function automatic logic [5:0] decode(input logic [7:0] a);
      decode = {a == OFS_SEQ, a == OFS_IRQ_MASK, a == OFS_IRQ_STAT,
                a == OFS_PC, a == OFS_STATUS, a == OFS_CAUSE};
   endfunction

   // Pins cross two flip-flops; the second stage and its one-cycle delayed copy feed logic.
   logic [2:0]        sync1_reg;
   logic [2:0]        sync2_reg;
   logic              osc_prev_reg;
   logic              pin_prev_reg;
   logic              bor_low;
   logic              pin_low;
   logic              osc_tick;
   logic              pin_fall;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg    <= 3'h1;
         sync2_reg    <= 3'h1;
         osc_prev_reg <= 1'b0;
         pin_prev_reg <= 1'b1;
      end else begin
         sync1_reg    <= {osc_clk_i, brownout_i, external_reset_pin_n_i};
         sync2_reg    <= sync1_reg;
         osc_prev_reg <= sync2_reg[2];
         pin_prev_reg <= sync2_reg[0];
      end
   end

   // A dip is only honoured while brown-out reset is enabled.
   assign bor_low  = sync2_reg[1] & brownout_enable_i;
   assign pin_low  = ~sync2_reg[0];
   assign osc_tick = sync2_reg[2] & ~osc_prev_reg;
   assign pin_fall = pin_low & pin_prev_reg;

   seq_state_t         state_reg, state_next;
   logic [CNT_W-1:0]   cnt_reg, cnt_next;
   logic               cold_reg, cold_next;
   logic [1:0]         cause_reg, cause_next;
   logic [7:0]         status_reg, status_next;
   logic [PC_W-1:0]    pc_reg, pc_next;
   logic [IRQ_W-1:0]   istat_reg, istat_next;
   logic [IRQ_W-1:0]   mask_reg, mask_next;
   logic [IRQ_W-1:0]   irq_set;
   logic               hold_reg, hold_next;
   logic               load_reg, load_next;
   logic               wdhold_reg, wdhold_next;
   logic               irq_reg, irq_next;
   avm_rsp_t           rsp_reg, rsp_next;
   logic               req;
   logic               take_wr;
   logic               wdt_reset;
   logic [5:0]         sel;
   logic               xtal;
   logic               power_up_delay_timer_on;

   assign req     = bus_i.read | bus_i.write;
   assign take_wr = bus_i.write & ~rsp_reg.waitrequest & bus_i.byteenable[0];
   assign sel     = decode(bus_i.address);
   assign xtal    = is_crystal(osc_mode_i);
   assign power_up_delay_timer_on = ~power_up_delay_enable_n_i;

   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      cold_next   = cold_reg;
      cause_next  = cause_reg;
      status_next = status_reg;
      pc_next     = pc_reg;
      mask_next   = mask_reg;
      irq_set     = '0;
      wdt_reset   = 1'b0;
      // Software writes come first so that a hardware event in the same cycle wins.
      if (take_wr) begin
         if (sel[0]) begin
            cause_next = bus_i.writedata[1:0];
         end
         if (sel[1]) begin
            status_next = bus_i.writedata[7:0];
         end
         if (sel[4]) begin
            mask_next = bus_i.writedata[IRQ_W-1:0];
         end
      end
      case (state_reg)
         ST_START: begin
            cnt_next  = '0;
            cold_next = 1'b0;
            if (cold_reg && power_up_delay_timer_on) begin
               state_next = ST_POWER_UP_DELAY_TIMER;
            end else if (xtal) begin
               state_next = ST_SETTLE;
            end else begin
               state_next = ST_CPU;
            end
         end
         ST_BROWNOUT: begin
            if (!bor_low) state_next = ST_START;
         end
         ST_POWER_UP_DELAY_TIMER: begin
            if (cnt_reg == CNT_W'(POWER_UP_DELAY_TIMER_CYCLES_P - 1)) begin
               cnt_next   = '0;
               state_next = xtal ? ST_SETTLE : ST_RUN;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_SETTLE: begin
            if (osc_tick) begin
               if (cnt_reg == CNT_W'(SETTLE_CYCLES_P - 1)) begin
                  state_next = ST_RUN;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
         end
         ST_CPU: begin
            if (cnt_reg == CNT_W'(CPU_START_CYCLES - 1)) begin
               state_next = ST_RUN;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_RUN: begin
            if (pin_fall) begin
               irq_set[IRQ_PIN] = 1'b1;
               pc_next          = PC_RESET;
               if (sleeping_i) begin
                  status_next = {3'b000, 2'b10, status_next[2:0]};
               end else begin
                  status_next[7:5] = 3'b000;
               end
            end else if (watchdog_expire_i) begin
               irq_set[IRQ_WDT] = 1'b1;
               if (sleeping_i) begin
                  status_next[4:3] = 2'b00;
                  pc_next          = PC_W'(current_pc_i + 1'b1);
                  state_next       = ST_START;
               end else begin
                  status_next = {3'b000, 2'b01, status_next[2:0]};
                  pc_next     = PC_RESET;
                  wdt_reset   = 1'b1;
               end
            end else if (wake_irq_i && sleeping_i) begin
               irq_set[IRQ_WAKE] = 1'b1;
               status_next[4:3]  = 2'b10;
               pc_next    = global_irq_enable_i ? PC_VECTOR : PC_W'(current_pc_i + 1'b1);
               state_next = ST_START;
            end
         end
         default: state_next = ST_START;
      endcase
      // A new dip from any state restarts the sequence, the power-up delay included.
      if (bor_low) begin
         state_next               = ST_BROWNOUT;
         cold_next                = 1'b1;
         cnt_next                 = '0;
         cause_next[BROWNOUT_BIT] = 1'b0;
         status_next              = {3'b000, 2'b11, status_next[2:0]};
         pc_next                  = PC_RESET;
         if (state_reg != ST_BROWNOUT) irq_set[IRQ_BOR] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg  <= ST_START;
         cnt_reg    <= '0;
         cold_reg   <= 1'b1;
         cause_reg  <= CAUSE_RST;
         status_reg <= STATUS_POR;
         pc_reg     <= PC_RESET;
         mask_reg   <= '0;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         cold_reg   <= cold_next;
         cause_reg  <= cause_next;
         status_reg <= status_next;
         pc_reg     <= pc_next;
         mask_reg   <= mask_next;
      end
   end

   // Core handshake, interrupt and bus answer.
   always_comb begin
      // The pin holds the core even after every delay has run out.
      hold_next   = (state_next != ST_RUN) || pin_low || wdt_reset;
      load_next   = hold_reg & ~hold_next;
      wdhold_next = (state_next == ST_SETTLE);
      istat_next  = istat_reg;
      if (take_wr && sel[3]) istat_next = istat_reg & ~bus_i.writedata[IRQ_W-1:0];
      istat_next  = istat_next | irq_set;
      istat_next[IRQ_READY] = istat_next[IRQ_READY] | load_next;
      irq_next    = |(istat_next & mask_next);
      rsp_next.waitrequest = ~(req & rsp_reg.waitrequest);
      rsp_next.readdata    = rsp_reg.readdata;
      if (bus_i.read && rsp_reg.waitrequest) begin
         rsp_next.readdata = '0;
         if (sel[0]) begin
            rsp_next.readdata[1:0] = cause_reg;
         end
         if (sel[1]) begin
            rsp_next.readdata[7:0] = status_reg;
         end
         if (sel[2]) begin
            rsp_next.readdata[PC_W-1:0] = pc_reg;
         end
         if (sel[3]) begin
            rsp_next.readdata[IRQ_W-1:0] = istat_reg;
         end
         if (sel[4]) begin
            rsp_next.readdata[IRQ_W-1:0] = mask_reg;
         end
         if (sel[5]) begin
            rsp_next.readdata[8:0] = {sleeping_i, pin_low, hold_reg, state_reg};
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold_reg   <= 1'b1;
         load_reg   <= 1'b0;
         wdhold_reg <= 1'b0;
         istat_reg  <= '0;
         irq_reg    <= 1'b0;
         rsp_reg    <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
      end else begin
         hold_reg   <= hold_next;
         load_reg   <= load_next;
         wdhold_reg <= wdhold_next;
         istat_reg  <= istat_next;
         irq_reg    <= irq_next;
         rsp_reg    <= rsp_next;
      end
   end

   assign bus_o           = rsp_reg;
   assign cpu_hold_o      = hold_reg;
   assign pc_load_o       = load_reg;
   assign pc_value_o      = pc_reg;
   assign status_value_o  = status_reg;
   assign watchdog_hold_o = wdhold_reg;
   assign irq_o           = irq_reg;
endmodule
`default_nettype wire

/* File: test/reset_supply_model.sv */
`timescale 1ns/1ns
`default_nettype none
module reset_supply_model (
   // Clock and bench commands
   input  wire logic clk_i,
   input  wire logic pin_low_i,
   input  wire logic dip_i,
   // Lines into the block
   output logic      external_reset_pin_n_o,
   output logic      brownout_o,
   output logic      osc_clk_o
);
   logic [2:0] div_reg = 3'h0;
   // The pin has a pull-up, so a released pin reads high, never a stale low.
   assign external_reset_pin_n_o = !pin_low_i;
   assign brownout_o = dip_i;
   // A crystal runs free, here at one eighth of the bus clock.
   assign osc_clk_o = div_reg[2];
   always @(posedge clk_i) div_reg <= div_reg + 3'h1;
endmodule
`default_nettype wire

/* File: test/reset_tracker_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module reset_tracker_checker (
   // Clock and reset
   input wire logic                    clk_i,
   input wire logic                    reset_i,
   // Register bus
   input wire reset_seq_pkg::avm_req_t bus_i,
   input wire reset_seq_pkg::avm_rsp_t bus_o,
   // Pin and core
   input wire logic                    external_reset_pin_n_i,
   input wire logic                    sleeping_i,
   input wire logic                    watchdog_expire_i,
   input wire logic                    wake_irq_i,
   input wire logic                    cpu_hold_o,
   input wire logic                    pc_load_o,
   input wire logic [12:0]             pc_value_o,
   input wire logic [7:0]              status_value_o,
   input wire logic                    watchdog_hold_o
);
   import reset_seq_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_kick; watchdog_expire_i && !sleeping_i && !cpu_hold_o; endsequence
   sequence s_restart; pc_load_o && pc_value_o == PC_RESET; endsequence
   sequence s_drop; $fell(external_reset_pin_n_i) && !cpu_hold_o && !sleeping_i; endsequence
   property p_bus_answer; (bus_i.read || bus_i.write) && bus_o.waitrequest |=> !bus_o.waitrequest; endproperty
   property p_bus_single; !bus_o.waitrequest |=> bus_o.waitrequest; endproperty
   property p_load_on_release; $fell(cpu_hold_o) |-> pc_load_o; endproperty
   property p_load_pulse; pc_load_o |=> !pc_load_o; endproperty
   property p_settle_holds; watchdog_hold_o |-> cpu_hold_o && !pc_load_o; endproperty
   property p_cold_image; $fell(reset_i) |-> status_value_o == STATUS_POR && cpu_hold_o; endproperty
   property p_watchdog; s_kick |=> cpu_hold_o && status_value_o[7:3] == 5'h01 ##1 s_restart; endproperty
   property p_wake; wake_irq_i && sleeping_i && !cpu_hold_o |=> cpu_hold_o && status_value_o[4:3] == 2'h2; endproperty
   property p_pin_holds; !external_reset_pin_n_i[*4] |-> cpu_hold_o; endproperty
   property p_pin_keeps; s_drop ##0 !external_reset_pin_n_i[*4] |=> status_value_o[4:3] == $past(status_value_o[4:3], 5); endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");
   a_bus_single: assert property (p_bus_single) else $error("bus answer too long");
   a_load_on_release: assert property (p_load_on_release) else $error("release without load");
   a_load_pulse: assert property (p_load_pulse) else $error("load pulse too long");
   a_settle_holds: assert property (p_settle_holds) else $error("core runs in settle");
   a_cold_image: assert property (p_cold_image) else $error("bad cold status");
   a_watchdog: assert property (p_watchdog) else $error("bad watchdog reset");
   a_wake: assert property (p_wake) else $error("bad wake flags");
   a_pin_holds: assert property (p_pin_holds) else $error("pin low not holding");
   a_pin_keeps: assert property (p_pin_keeps) else $error("pin reset changed flags");
endmodule
bind reset_timeout_and_cause_tracker reset_tracker_checker u_reset_tracker_checker (
   .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .bus_o(bus_o),
   .external_reset_pin_n_i(external_reset_pin_n_i), .sleeping_i(sleeping_i),
   .watchdog_expire_i(watchdog_expire_i), .wake_irq_i(wake_irq_i), .cpu_hold_o(cpu_hold_o),
   .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .status_value_o(status_value_o),
   .watchdog_hold_o(watchdog_hold_o));
`default_nettype wire

/* File: test/tb_reset_timeout_and_cause_tracker.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_reset_timeout_and_cause_tracker;
   import reset_seq_pkg::*;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   avm_req_t    req = '0;
   avm_rsp_t    rsp;
   osc_mode_t   mode = OSC_INTERNAL_RC_CLOCK_MODE;
   logic        pin_low = 1'b0, dip = 1'b0, delay_n = 1'b1, sleep = 1'b0, saw = 1'b0;
   logic        kick = 1'b0, wake = 1'b0, global_irq_enable = 1'b0, pin_n, low_v, osc, hold, load, wdh, irq;
   logic [12:0] cur_pc = 13'h0123, pcv;
   logic [7:0]  stv;
   logic [31:0] q;
   int          mismatches = 0, n_compared = 0, n, lo, hi;
   row_t        rows [11] = '{'{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 8'h18}, '{0, 8'h08, 0, 0},
      '{0, 8'h10, 0, 0}, '{0, 8'h14, 0, 8'h20}, '{1, 8'h00, 3, 0}, '{0, 8'h00, 0, 3},
      '{1, 8'h08, 8'h55, 0}, '{0, 8'h08, 0, 0}, '{1, 8'h40, 8'hff, 0}, '{0, 8'h40, 0, 0}};
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   reset_supply_model u_reset_supply_model (.clk_i(clk_i), .pin_low_i(pin_low), .dip_i(dip),
      .external_reset_pin_n_o(pin_n), .brownout_o(low_v), .osc_clk_o(osc));
   reset_timeout_and_cause_tracker #(.POWER_UP_DELAY_TIMER_CYCLES_P(20), .SETTLE_CYCLES_P(8))
      u_reset_timeout_and_cause_tracker (.clk_i(clk_i), .reset_i(reset_i), .bus_i(req),
      .bus_o(rsp), .brownout_i(low_v), .brownout_enable_i(1'b1),
      .power_up_delay_enable_n_i(delay_n), .osc_mode_i(mode), .external_reset_pin_n_i(pin_n),
      .osc_clk_i(osc), .sleeping_i(sleep), .watchdog_expire_i(kick), .wake_irq_i(wake),
      .global_irq_enable_i(global_irq_enable), .current_pc_i(cur_pc), .cpu_hold_o(hold), .pc_load_o(load),
      .pc_value_o(pcv), .status_value_o(stv), .watchdog_hold_o(wdh), .irq_o(irq));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
      @(posedge clk_i);
      while (rsp.waitrequest !== 1'b0 && k < 20) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 20) mismatches++;
      q = rsp.readdata;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
      bus(1'b0, a, 32'h0);
      check(what, q, e);
   endtask
   task automatic wait_load(output int c);
      c = 0;
      while (load !== 1'b1 && c < 3000) begin
         @(posedge clk_i);
         c++;
         if (wdh === 1'b1) saw = 1'b1;
      end
      if (c >= 3000) mismatches++;
   endtask
   task automatic pulse(input bit w);
      if (w) wake <= 1'b1;
      else kick <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      kick <= 1'b0;
      wait_load(n);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      wrap_up;
   end
   initial begin
      // Crystal modes add eight oscillator periods; a zero enable adds the power-up delay.
      for (int i = 0; i < 12; i++) begin
         mode <= osc_mode_t'(i / 2);
         delay_n <= i[0];
         reset_i <= 1'b1;
         repeat (20) @(posedge clk_i);
         reset_i <= 1'b0;
         saw = 1'b0;
         wait_load(n);
         lo = (i / 2 < 3) ? (i[0] ? 57 : 77) : (i[0] ? 126 : 21);
         hi = lo + ((i / 2 < 3) ? 16 : 4);
         check("start time", 32'(n >= lo && n <= hi), 32'h1);
         check("settle hold", 32'(saw), 32'(i / 2 < 3));
      end
      $display("test start times finished");
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) check("register", q, rows[i].e);
      end
      check("irq masked", 32'(irq), 32'h0);
      bus(1'b1, 8'h0c, 32'h1f);
      bus(1'b1, 8'h10, 32'h02);
      pin_low <= 1'b1;
      repeat (10) @(posedge clk_i);
      check("pin hold", 32'(hold), 32'h1);
      pin_low <= 1'b0;
      wait_load(n);
      check("pin release", 32'(n <= 5), 32'h1);
      check("pin flags", 32'(stv[4:3]), 32'h3);
      rd(8'h00, 32'h3, "cause after pin");
      check("irq raised", 32'(irq), 32'h1);
      bus(1'b1, 8'h0c, 32'h1f);
      @(posedge clk_i);
      check("irq cleared", 32'(irq), 32'h0);
      $display("test registers and pin finished");
      pin_low <= 1'b1;
      reset_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      repeat (300) @(posedge clk_i);
      pin_low <= 1'b0;
      wait_load(n);
      check("late pin", 32'(n <= 5), 32'h1);
      bus(1'b1, 8'h00, 32'h3);
      dip <= 1'b1;
      repeat (10) @(posedge clk_i);
      check("brownout hold", 32'(hold), 32'h1);
      dip <= 1'b0;
      repeat (50) @(posedge clk_i);
      dip <= 1'b1;
      repeat (10) @(posedge clk_i);
      dip <= 1'b0;
      wait_load(n);
      check("restart", 32'(n >= 126 && n <= 134), 32'h1);
      rd(8'h00, 32'h2, "cause after brownout");
      rd(8'h04, 32'h18, "status after brownout");
      pulse(1'b0);
      check("watchdog pc", 32'(pcv), 32'h0);
      check("watchdog status", 32'(stv[7:3]), 32'h01);
      rd(8'h00, 32'h2, "cause after watchdog");
      $display("test brownout and watchdog finished");
      for (int g = 0; g < 2; g++) begin
         sleep <= 1'b1;
         global_irq_enable <= g[0];
         pulse(1'b1);
         check("wake pc", 32'(pcv), g ? 32'h4 : 32'h124);
         check("wake flags", 32'(stv[4:3]), 32'h2);
         sleep <= 1'b0;
         @(posedge clk_i);
      end
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      repeat (4) @(posedge clk_i);
      check("wake ignored", 32'(hold), 32'h0);
      sleep <= 1'b1;
      pin_low <= 1'b1;
      repeat (10) @(posedge clk_i);
      pin_low <= 1'b0;
      wait_load(n);
      check("sleep pin status", 32'(stv[7:3]), 32'h02);
      sleep <= 1'b0;
      $display("test wake and sleep finished");
      wrap_up;
   end
endmodule
`default_nettype wire
